//--- addr_map_pkg.sv
// address map constants and types for the system address decoder
package addr_map_pkg;

    // ------------------------------------------------------------
    // mapping modes and target regions
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MAP_BOOT  = 2'h0,
        MAP_FLASH = 2'h1,
        MAP_RAM   = 2'h2,
        MAP_EXT   = 2'h3
    } map_mode_e;

    typedef enum logic [6:0] {
        RGN_NONE  = 7'h01,
        RGN_FLASH = 7'h02,
        RGN_SRAM  = 7'h04,
        RGN_BOOT  = 7'h08,
        RGN_EXT   = 7'h10,
        RGN_LSPER = 7'h20,
        RGN_HSPER = 7'h40
    } region_e;

    // ------------------------------------------------------------
    // region bases
    // ------------------------------------------------------------
    localparam logic [31:0] FLASH_BASE   = 32'h0000_0000;
    localparam logic [31:0] SRAM_BASE    = 32'h4000_0000;
    localparam logic [31:0] ONCHIP_TOP   = 32'h8000_0000;
    localparam logic [31:0] EXT_BASE     = 32'h8000_0000;
    localparam logic [31:0] LSPER_BASE   = 32'he000_0000;
    localparam logic [31:0] HSPER_BASE   = 32'hffe0_0000;
    localparam logic [31:0] PER_BYTES    = 32'h0020_0000;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int          WIN_BITS     = 6;
    localparam int          SLOT_LSB     = 14;
    localparam int          SLOT_BITS    = 7;
    localparam int          BANK_LSB     = 24;
    localparam int          BANK_BITS    = 2;
    localparam int          EXT_TOP_LSB  = 26;
    localparam logic [5:0]  EXT_TOP_VAL  = 6'h20;
    localparam int          WORD_LSB     = 2;

    // ------------------------------------------------------------
    // vector offsets inside the low window
    // ------------------------------------------------------------
    localparam logic [5:0]  VEC_RESET    = 6'h00;
    localparam logic [5:0]  VEC_UNDEF    = 6'h04;
    localparam logic [5:0]  VEC_SWI      = 6'h08;
    localparam logic [5:0]  VEC_PABT     = 6'h0c;
    localparam logic [5:0]  VEC_DABT     = 6'h10;
    localparam logic [5:0]  VEC_RSVD     = 6'h14;
    localparam logic [5:0]  VEC_IRQ      = 6'h18;
    localparam logic [5:0]  VEC_FIQ      = 6'h1c;

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    localparam logic [1:0]  STRAP_ONCHIP = 2'h3;
    localparam logic [1:0]  STRAP_WAIT   = 2'h3;

endpackage

//--- address_decode_remap_abort.sv
// system address decoder with low vector remap and abort generation
// Operation
// - peripheral areas: 2 MB, 128 slots of 16 KB
// - peripheral registers word aligned, no lane steering
// - vectors fixed words from 0x00 to 0x1c
// - reset enters boot loader mapping
// - user flash mapping leaves window unredirected
// - user RAM mapping redirects window to SRAM
// - straps not 11 set bootExternal only, mapping mode unaffected
// - redirected window covers 64 bytes at zero
// - mirrored area still answers at native address
// - other regions fixed whatever the mode
// - boot block at top of on-chip space
// - reserved or unassigned access gives matching abort
// - gap after flash up to SRAM aborts
// - gap after SRAM up to boot aborts
// - reserved, unassigned peripheral and unserved external abort
// - fetch from any peripheral area prefetch aborts
// - undefined offset in existing slot no abort
// - prefetch abort travels with fetched instruction
module address_decode_remap_abort #(
    parameter logic [31:0]  FLASH_BYTES = 32'h0004_0000,
    parameter logic [31:0]  SRAM_BYTES  = 32'h0000_4000,
    parameter logic [31:0]  BOOT_BYTES  = 32'h0000_2000,
    parameter logic [2:0]   EXT_BANKS   = 3'h4,
    parameter logic [127:0] LS_PRESENT  = 128'h8000_0000_0000_0000_0000_0000_0000_3fbf,
    parameter logic [127:0] HS_PRESENT  = 128'h8000_0000_0000_0000_0000_0000_0000_0001
) (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire logic                     reqValid,
    input  wire logic [31:0]              reqAddr,
    input  wire logic                     reqFetch,
    input  wire logic                     reqWrite,
    input  wire logic                     mapModeLoad,
    input  wire addr_map_pkg::map_mode_e  mapModeIn,
    input  wire logic [1:0]               bootSelectPins,
    output logic                          respValid,
    output logic [31:0]                   respAddr,
    output addr_map_pkg::region_e         respRegion,
    output logic [6:0]                    respSlot,
    output logic [1:0]                    respBank,
    output logic                          respFetch,
    output logic                          respWrite,
    output logic                          dataAbort,
    output logic                          prefetchAbort,
    output logic [31:0]                   abortAddr,
    output addr_map_pkg::map_mode_e       mapMode,
    output logic                          bootExternal,
    output logic                          strapValid
);
    import addr_map_pkg::*;

    localparam logic [31:0] BOOT_BASE = ONCHIP_TOP - BOOT_BYTES;
    localparam logic [31:0] SRAM_END  = SRAM_BASE + SRAM_BYTES;
    localparam logic [31:0] LSPER_END = LSPER_BASE + PER_BYTES;

    remap_if rmp ();

    logic [1:0]  strapBits;
    logic        strapDone;

    map_mode_e   modeReg;
    map_mode_e   modeNext;

    logic [31:0] mAddr;
    region_e     region;
    logic [6:0]  slot;
    logic [1:0]  bank;
    logic        isPeriph;
    logic        abort;

    logic        respValidReg;
    logic        respValidNext;
    logic [31:0] respAddrReg;
    logic [31:0] respAddrNext;
    region_e     respRegionReg;
    region_e     respRegionNext;
    logic [6:0]  respSlotReg;
    logic [6:0]  respSlotNext;
    logic [1:0]  respBankReg;
    logic [1:0]  respBankNext;
    logic        respFetchReg;
    logic        respFetchNext;
    logic        respWriteReg;
    logic        respWriteNext;
    logic        dataAbortReg;
    logic        dataAbortNext;
    logic        prefetchAbortReg;
    logic        prefetchAbortNext;
    logic [31:0] abortAddrReg;
    logic [31:0] abortAddrNext;
    logic        bootExternalReg;
    logic        bootExternalNext;

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    strap_sampler #(
        .WIDTH (2)
    ) u_strap (
        .clk     (clk),
        .srst    (srst),
        .pins    (bootSelectPins),
        .sampled (strapBits),
        .valid   (strapDone)
    );

    vector_remap #(
        .BOOT_BASE (BOOT_BASE)
    ) u_remap (
        .rm (rmp.remapper)
    );

    assign rmp.addr = reqAddr;
    assign rmp.mode = modeReg;
    assign mAddr    = rmp.mapped;

    // ------------------------------------------------------------
    // mapping mode
    // ------------------------------------------------------------
    always_comb begin
        modeNext         = modeReg;
        bootExternalNext = bootExternalReg;
        if (mapModeLoad) begin
            modeNext = mapModeIn;
        end
        if (strapDone) begin
            bootExternalNext = (strapBits != STRAP_ONCHIP);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            modeReg         <= MAP_BOOT;
            bootExternalReg <= 1'b0;
        end else begin
            modeReg         <= modeNext;
            bootExternalReg <= bootExternalNext;
        end
    end

    // ------------------------------------------------------------
    // region decode of the remapped address
    // ------------------------------------------------------------
    always_comb begin
        slot     = mAddr[SLOT_LSB +: SLOT_BITS];
        bank     = mAddr[BANK_LSB +: BANK_BITS];
        isPeriph = 1'b0;
        region   = RGN_NONE;
        // native addresses decode the same with or without remap
        if (mAddr < FLASH_BASE + FLASH_BYTES) begin
            region = RGN_FLASH;
        end else if (mAddr < SRAM_BASE) begin
            region = RGN_NONE;
        end else if (mAddr < SRAM_END) begin
            region = RGN_SRAM;
        end else if (mAddr < BOOT_BASE) begin
            region = RGN_NONE;
        end else if (mAddr < ONCHIP_TOP) begin
            region = RGN_BOOT;
        end else if (mAddr < LSPER_BASE) begin
            if ((mAddr[31:EXT_TOP_LSB] == EXT_TOP_VAL) && ({1'b0, bank} < EXT_BANKS)) begin
                region = RGN_EXT;
            end else begin
                region = RGN_NONE;
            end
        end else if (mAddr < LSPER_END) begin
            isPeriph = 1'b1;
            region   = LS_PRESENT[slot] ? RGN_LSPER : RGN_NONE;
        end else if (mAddr < HSPER_BASE) begin
            isPeriph = 1'b1;
            region   = RGN_NONE;
        end else begin
            isPeriph = 1'b1;
            region   = HS_PRESENT[slot] ? RGN_HSPER : RGN_NONE;
        end
        abort = (region == RGN_NONE) || (isPeriph && reqFetch);
    end

    // ------------------------------------------------------------
    // registered answer, one cycle after the request
    // ------------------------------------------------------------
    always_comb begin
        respValidNext     = reqValid;
        respAddrNext      = respAddrReg;
        respRegionNext    = respRegionReg;
        respSlotNext      = respSlotReg;
        respBankNext      = respBankReg;
        respFetchNext     = respFetchReg;
        respWriteNext     = respWriteReg;
        dataAbortNext     = 1'b0;
        prefetchAbortNext = 1'b0;
        abortAddrNext     = abortAddrReg;
        if (reqValid) begin
            respAddrNext   = mAddr;
            if (isPeriph) begin
                // whole-word access only, no byte lane steering
                respAddrNext = {mAddr[31:WORD_LSB], {WORD_LSB{1'b0}}};
            end
            respRegionNext    = abort ? RGN_NONE : region;
            respSlotNext      = slot;
            respBankNext      = bank;
            respFetchNext     = reqFetch;
            respWriteNext     = reqWrite;
            dataAbortNext     = abort && !reqFetch;
            prefetchAbortNext = abort && reqFetch;
            if (abort) begin
                abortAddrNext = reqAddr;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            respValidReg     <= 1'b0;
            respAddrReg      <= 32'h0000_0000;
            respRegionReg    <= RGN_NONE;
            respSlotReg      <= 7'h00;
            respBankReg      <= 2'h0;
            respFetchReg     <= 1'b0;
            respWriteReg     <= 1'b0;
            dataAbortReg     <= 1'b0;
            prefetchAbortReg <= 1'b0;
            abortAddrReg     <= 32'h0000_0000;
        end else begin
            respValidReg     <= respValidNext;
            respAddrReg      <= respAddrNext;
            respRegionReg    <= respRegionNext;
            respSlotReg      <= respSlotNext;
            respBankReg      <= respBankNext;
            respFetchReg     <= respFetchNext;
            respWriteReg     <= respWriteNext;
            dataAbortReg     <= dataAbortNext;
            prefetchAbortReg <= prefetchAbortNext;
            abortAddrReg     <= abortAddrNext;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign respValid     = respValidReg;
    assign respAddr      = respAddrReg;
    assign respRegion    = respRegionReg;
    assign respSlot      = respSlotReg;
    assign respBank      = respBankReg;
    assign respFetch     = respFetchReg;
    assign respWrite     = respWriteReg;
    assign dataAbort     = dataAbortReg;
    assign prefetchAbort = prefetchAbortReg;
    assign abortAddr     = abortAddrReg;
    assign mapMode       = modeReg;
    assign bootExternal  = bootExternalReg;
    assign strapValid    = strapDone;
endmodule

//--- address_decode_remap_abort_bench.sv
// self-checking bench for the system address decoder
module address_decode_remap_abort_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import addr_map_pkg::*;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end

    logic        clk = 1'b0;
    logic        srst;
    logic        reqValid, reqFetch, reqWrite, mapModeLoad;
    logic [31:0] reqAddr, respAddr, abortAddr;
    map_mode_e   mapModeIn, mapMode;
    logic [1:0]  bootSelectPins, respBank;
    logic        respValid, respFetch, respWrite, dataAbort, prefetchAbort;
    logic        bootExternal, strapValid, fetchAbortTag;
    region_e     respRegion;
    logic [6:0]  respSlot;
    int          errors = 0;
    int          num_checks = 0;

    always #5 clk = ~clk;

    address_decode_remap_abort i_dut (
        .clk(clk), .srst(srst), .reqValid(reqValid), .reqAddr(reqAddr), .reqFetch(reqFetch),
        .reqWrite(reqWrite), .mapModeLoad(mapModeLoad), .mapModeIn(mapModeIn),
        .bootSelectPins(bootSelectPins), .respValid(respValid), .respAddr(respAddr),
        .respRegion(respRegion), .respSlot(respSlot), .respBank(respBank), .respFetch(respFetch),
        .respWrite(respWrite), .dataAbort(dataAbort), .prefetchAbort(prefetchAbort),
        .abortAddr(abortAddr), .mapMode(mapMode), .bootExternal(bootExternal),
        .strapValid(strapValid));

    core_model i_core (
        .clk(clk), .respValid(respValid), .respFetch(respFetch), .prefetchAbort(prefetchAbort),
        .reqValid(reqValid), .reqAddr(reqAddr), .reqFetch(reqFetch), .reqWrite(reqWrite),
        .fetchAbortTag(fetchAbortTag));

    // ------------------------------------------------------------
    // shared steps
    // ------------------------------------------------------------
    task automatic print_verdict;
        if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic acc(input logic [31:0] a, input logic f, input region_e r,
                       input logic [31:0] ea, input logic ab);
        i_core.issue(a, f, ~f);
        `CHK(respValid, 1'b1)
        `CHK(respRegion, r)
        `CHK(dataAbort, ab & ~f)
        `CHK(prefetchAbort, ab & f)
        `CHK(respFetch, f)
        `CHK(respWrite, ~f)
        if (ab) `CHK(abortAddr, a)
        else `CHK(respAddr, ea)
    endtask

    task automatic set_mode(input map_mode_e m);
        @(negedge clk);
        mapModeLoad = 1'b1;
        mapModeIn = m;
        @(negedge clk);
        mapModeLoad = 1'b0;
        `CHK(mapMode, m)
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic do_reset(input logic [1:0] pins);
        int n;
        @(negedge clk);
        bootSelectPins = pins;
        srst = 1'b1;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        `CHK(mapMode, MAP_BOOT)
        n = 0;
        while (strapValid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        `CHK(strapValid, 1'b1)
        `CHK(bootExternal, pins != 2'h3)
    endtask

    task automatic t_window;
        logic [31:0] base [4];
        region_e     rg [4];
        base = '{32'h7fff_e000, 32'h0, 32'h4000_0000, 32'h8000_0000};
        rg = '{RGN_BOOT, RGN_FLASH, RGN_SRAM, RGN_EXT};
        for (int i = 0; i < 4; i++) begin
            set_mode(map_mode_e'(i));
            for (int v = 0; v < 8; v++) begin
                acc(32'(v * 4), 1'b1, rg[i], base[i] + 32'(v * 4), 1'b0);
            end
            acc(32'h3c, 1'b0, rg[i], base[i] + 32'h3c, 1'b0);
            acc(32'h40, 1'b0, RGN_FLASH, 32'h40, 1'b0);
            acc(32'h7fff_e010, 1'b0, RGN_BOOT, 32'h7fff_e010, 1'b0);
            acc(base[i] + 32'h1c, 1'b0, rg[i], base[i] + 32'h1c, 1'b0);
            acc(32'h4000_3ffc, 1'b0, RGN_SRAM, 32'h4000_3ffc, 1'b0);
        end
    endtask

    task automatic t_aborts;
        logic [31:0] bad [8];
        bad = '{32'h0004_0000, 32'h3fff_fffc, 32'h4000_4000, 32'h7fff_dffc,
                32'h8400_0000, 32'he001_8000, 32'he020_0000, 32'hffe0_4000};
        for (int i = 0; i < 8; i++) begin
            acc(bad[i], 1'b0, RGN_NONE, 32'h0, 1'b1);
            acc(bad[i], 1'b1, RGN_NONE, 32'h0, 1'b1);
        end
    endtask

    task automatic t_periph;
        acc(32'he000_d002, 1'b0, RGN_LSPER, 32'he000_d000, 1'b0);
        `CHK(respSlot, 7'h03)
        acc(32'he01f_c000, 1'b0, RGN_LSPER, 32'he01f_c000, 1'b0);
        `CHK(respSlot, 7'h7f)
        acc(32'hffff_c004, 1'b0, RGN_HSPER, 32'hffff_c004, 1'b0);
        `CHK(respSlot, 7'h7f)
        acc(32'h0000_0100, 1'b1, RGN_FLASH, 32'h0000_0100, 1'b0);
        @(negedge clk);
        `CHK(fetchAbortTag, 1'b0)
        acc(32'he000_c000, 1'b1, RGN_NONE, 32'h0, 1'b1);
        @(negedge clk);
        `CHK(fetchAbortTag, 1'b1)
        acc(32'h8300_0010, 1'b0, RGN_EXT, 32'h8300_0010, 1'b0);
        `CHK(respBank, 2'h3)
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        mapModeLoad = 1'b0;
        mapModeIn = MAP_BOOT;
        bootSelectPins = 2'h1;
        do_reset(2'h1);
        t_window;
        t_aborts;
        t_periph;
        set_mode(MAP_RAM);
        do_reset(2'h3);
        print_verdict;
    end

    initial begin
        #50us;
        errors++;
        print_verdict;
    end
endmodule

//--- address_decode_remap_abort_monitor.sv
// concurrent checks on the address decoder ports
module address_decode_remap_abort_monitor #(
    parameter logic [31:0] FLASH_BYTES = 32'h0004_0000
) (
    input wire logic                    clk,
    input wire logic                    srst,
    input wire logic                    reqValid,
    input wire logic [31:0]             reqAddr,
    input wire logic                    reqFetch,
    input wire logic                    mapModeLoad,
    input wire addr_map_pkg::map_mode_e mapModeIn,
    input wire logic                    respValid,
    input wire logic [31:0]             respAddr,
    input wire addr_map_pkg::region_e   respRegion,
    input wire logic                    respFetch,
    input wire logic                    dataAbort,
    input wire logic                    prefetchAbort,
    input wire logic [31:0]             abortAddr,
    input wire addr_map_pkg::map_mode_e mapMode
);
    timeunit 1ns;
    timeprecision 100ps;
    import addr_map_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    a_resp_one_cycle: assert property (reqValid |=> respValid)
        else $error("no response one cycle after request");
    a_reset_boot_map: assert property ($fell(srst) |-> mapMode == MAP_BOOT)
        else $error("mapping not boot after reset");
    a_mode_load: assert property (mapModeLoad |=> mapMode == $past(mapModeIn))
        else $error("mapping mode not loaded");
    a_window_ram: assert property (reqValid && reqAddr < 32'h40 && mapMode == MAP_RAM
        |=> respAddr == (SRAM_BASE | $past(reqAddr)))
        else $error("ram window not redirected");
    a_window_flash: assert property (reqValid && reqAddr < 32'h40 && mapMode == MAP_FLASH
        |=> respAddr == $past(reqAddr) && respRegion == RGN_FLASH)
        else $error("flash window redirected");
    a_gap_abort: assert property (reqValid && reqAddr >= FLASH_BYTES && reqAddr < SRAM_BASE
        |=> (dataAbort || prefetchAbort) && respRegion == RGN_NONE)
        else $error("flash gap did not abort");
    a_periph_fetch: assert property (reqValid && reqFetch && reqAddr[31:29] == 3'h7
        |=> prefetchAbort && !dataAbort)
        else $error("peripheral fetch not aborted");
    a_abort_kind: assert property ((dataAbort || prefetchAbort)
        |-> respValid && prefetchAbort == respFetch && respRegion == RGN_NONE)
        else $error("abort kind wrong");
    a_abort_addr: assert property ((dataAbort || prefetchAbort) |-> abortAddr == $past(reqAddr))
        else $error("abort address wrong");
    a_abort_hold: assert property (!(dataAbort || prefetchAbort) |-> $stable(abortAddr))
        else $error("abort address moved");
    a_boot_native: assert property (reqValid && reqAddr[31:13] == 19'h3ffff
        |=> respRegion == RGN_BOOT && respAddr == $past(reqAddr))
        else $error("boot block not at native place");
endmodule

bind address_decode_remap_abort address_decode_remap_abort_monitor #(.FLASH_BYTES(FLASH_BYTES)) i_monitor (
    .clk(clk), .srst(srst), .reqValid(reqValid), .reqAddr(reqAddr), .reqFetch(reqFetch),
    .mapModeLoad(mapModeLoad), .mapModeIn(mapModeIn), .respValid(respValid), .respAddr(respAddr),
    .respRegion(respRegion), .respFetch(respFetch), .dataAbort(dataAbort),
    .prefetchAbort(prefetchAbort), .abortAddr(abortAddr), .mapMode(mapMode));

//--- core_model.sv
// processor core stand-in issuing fetches and data accesses
module core_model (
    input  wire logic   clk,
    input  wire logic   respValid,
    input  wire logic   respFetch,
    input  wire logic   prefetchAbort,
    output logic        reqValid,
    output logic [31:0] reqAddr,
    output logic        reqFetch,
    output logic        reqWrite,
    output logic        fetchAbortTag
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        reqValid = 1'b0;
        reqAddr = 32'h0;
        reqFetch = 1'b0;
        reqWrite = 1'b0;
        fetchAbortTag = 1'b0;
    end
    // abort flag kept with the fetched word
    always @(posedge clk) begin
        if (respValid && respFetch) begin
            fetchAbortTag <= prefetchAbort;
        end
    end
    // single-cycle request; released lines show the inverse
    task automatic issue(input logic [31:0] a, input logic f, input logic w);
        @(negedge clk);
        reqValid = 1'b1;
        reqAddr = a;
        reqFetch = f;
        reqWrite = w;
        @(negedge clk);
        reqValid = 1'b0;
        reqAddr = ~a;
        reqFetch = ~f;
        reqWrite = ~w;
    endtask
endmodule

//--- remap_if.sv
// carrier between the decoder and its low-window remapper
interface remap_if;
    import addr_map_pkg::*;

    logic [31:0] addr;
    map_mode_e   mode;
    logic [31:0] mapped;
    logic        inWindow;

    modport requester (output addr, output mode, input mapped, input inWindow);
    modport remapper  (input addr, input mode, output mapped, output inWindow);
endinterface

//--- strap_sampler.sv
// synchronises boot select straps and captures them after reset release
module strap_sampler #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] pins,
    output logic      [WIDTH-1:0] sampled,
    output logic                  valid
);
    import addr_map_pkg::*;

    logic [WIDTH-1:0] s1Reg;
    logic [WIDTH-1:0] s2Reg;
    logic [WIDTH-1:0] s3Reg;
    logic [1:0]       waitReg;
    logic [1:0]       waitNext;
    logic [WIDTH-1:0] sampledReg;
    logic [WIDTH-1:0] sampledNext;
    logic             validReg;
    logic             validNext;

    // ------------------------------------------------------------
    // three-stage synchroniser per pin
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_sync
            always_ff @(posedge clk) begin
                if (srst) begin
                    s1Reg[i] <= 1'b0;
                    s2Reg[i] <= 1'b0;
                    s3Reg[i] <= 1'b0;
                end else begin
                    s1Reg[i] <= pins[i];
                    s2Reg[i] <= s1Reg[i];
                    s3Reg[i] <= s2Reg[i];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // capture once the chain is filled and stable
    // ------------------------------------------------------------
    always_comb begin
        waitNext    = waitReg;
        sampledNext = sampledReg;
        validNext   = validReg;
        if (waitReg != STRAP_WAIT) begin
            waitNext = waitReg + 2'h1;
        end else if (!validReg && (s2Reg == s3Reg)) begin
            sampledNext = s3Reg;
            validNext   = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            waitReg    <= 2'h0;
            sampledReg <= '0;
            validReg   <= 1'b0;
        end else begin
            waitReg    <= waitNext;
            sampledReg <= sampledNext;
            validReg   <= validNext;
        end
    end

    assign sampled = sampledReg;
    assign valid   = validReg;
endmodule

//--- vector_remap.sv
// low vector window redirection by mapping mode
module vector_remap #(
    parameter logic [31:0] BOOT_BASE = 32'h7fff_e000
) (
    remap_if.remapper rm
);
    import addr_map_pkg::*;

    always_comb begin
        rm.inWindow = (rm.addr[31:WIN_BITS] == '0);
        rm.mapped   = rm.addr;
        if (rm.inWindow) begin
            // offset kept so each vector stays at its own word
            case (rm.mode)
                MAP_BOOT:  rm.mapped = {BOOT_BASE[31:WIN_BITS], rm.addr[WIN_BITS-1:0]};
                MAP_FLASH: rm.mapped = rm.addr;
                MAP_RAM:   rm.mapped = {SRAM_BASE[31:WIN_BITS], rm.addr[WIN_BITS-1:0]};
                MAP_EXT:   rm.mapped = {EXT_BASE[31:WIN_BITS], rm.addr[WIN_BITS-1:0]};
            endcase
        end
    end
endmodule
